// ===== sbc_ctrl_pkg.sv
// package: register map, field layout, reset values, modes and timing of the control registers
package sbc_ctrl_pkg;
	// register addresses
	localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
	localparam logic [6:0] ADDR_HW_CONFIG = 7'h02;
	// frame layout, bits numbered in shift order
	localparam int FRAME_BITS = 16;
	localparam int ADDR_BITS = 7;
	localparam int WRITE_BIT = 7;
	localparam int DATA_LO = 8;
	// mode and supply field positions
	localparam int MS_MODE_LO = 6;
	localparam int MS_V3_ON = 5;
	localparam int MS_V2_LO = 3;
	localparam int MS_OV_REACT = 2;
	localparam int MS_RT_LO = 0;
	// hardware configuration field positions
	localparam int HW_VSEL = 7;
	localparam int HW_RO_SOFT = 6;
	localparam int HW_FO_SW = 5;
	localparam int HW_UV_KEEP = 4;
	localparam int HW_LS = 3;
	localparam int HW_LS_STOP = 1;
	localparam int HW_CFG = 0;
	// reset values, masks of bits that survive restart or soft reset, and the writable mask
	localparam logic [7:0] MS_RESET = 8'h00;
	localparam logic [7:0] HW_RESET = 8'h00;
	localparam logic [7:0] MS_RESTART_KEEP = 8'h23;
	localparam logic [7:0] HW_RESTART_KEEP = 8'hD9;
	localparam logic [7:0] HW_SOFT_KEEP = 8'hC9;
	localparam logic [7:0] HW_WRITABLE = 8'hFB;
	// operating mode codes
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_SLEEP = 2'h1,
		MODE_STOP = 2'h2,
		MODE_SOFT_RESET = 2'h3
	} op_mode_t;
	// second regulator codes
	typedef enum logic [1:0] {
		V2_OFF = 2'h0,
		V2_NORMAL = 2'h1,
		V2_NORM_STOP = 2'h2,
		V2_ALWAYS = 2'h3
	} v2_mode_t;
	// present device state, one-hot, from the outer state machine
	typedef enum logic [3:0] {
		ST_NORMAL = 4'h1,
		ST_SLEEP = 4'h2,
		ST_STOP = 4'h4,
		ST_FAIL_SAFE = 4'h8
	} sbc_state_t;
	// soft reset pulse sequencing
	typedef enum logic [1:0] {
		SR_IDLE = 2'h1,
		SR_ACTIVE = 2'h2
	} soft_state_t;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SOFT_RESET_LOW_NS = 10000;
	localparam int SOFT_RESET_CYCLES = (SOFT_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : sbc_ctrl_pkg

// ===== spi_frame_port.sv
// serial frame port: pin synchronisers, 16-bit shift in, 8-bit shift out, frame completion
`timescale 1ns/1ns
`default_nettype none
module spi_frame_port
	import sbc_ctrl_pkg::*;
#(
	parameter int BITS = FRAME_BITS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// serial pins
	input wire logic spi_clk_pin,
	input wire logic spi_cs_n_pin,
	input wire logic spi_mosi_pin,
	output logic spi_miso,
	output logic spi_miso_oe,
	// register side
	input wire logic [7:0] read_data,
	output logic [6:0] live_addr,
	output logic frame_valid,
	output logic frame_write,
	output logic [6:0] frame_addr,
	output logic [7:0] frame_data
);
	initial begin
		if (BITS != FRAME_BITS) $error("frame length must be %0d", FRAME_BITS);
	end
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic clk_prev;
	logic cs_prev_n;
	logic [BITS-1:0] in_shift;
	logic [7:0] out_shift;
	logic [4:0] count;
	logic sclk;
	logic cs_n;
	logic rise;
	logic fall;

	// two stages per pin; only the second stage feeds logic
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync_a <= 3'h4; // idle levels: deselected, clock low, so no false edge after reset
			sync_b <= 3'h4;
			clk_prev <= 1'b0;
			cs_prev_n <= 1'b1;
		end else begin
			sync_a <= {spi_cs_n_pin, spi_clk_pin, spi_mosi_pin};
			sync_b <= sync_a;
			clk_prev <= sync_b[1];
			cs_prev_n <= sync_b[2];
		end
	end
	assign sclk = sync_b[1];
	assign cs_n = sync_b[2];
	assign rise = !cs_n && sclk && !clk_prev;
	assign fall = !cs_n && !sclk && clk_prev;
	// after eight bits the address sits in bits 8 to 14; only read at that point
	assign live_addr = in_shift[DATA_LO +: ADDR_BITS];

	// sample on rising edge, least significant bit first
	always_ff @(posedge core_clk) begin
		if (rst) begin
			in_shift <= '0;
			count <= 5'h00;
		end else if (cs_n && !cs_prev_n) begin
			count <= 5'h00;
		end else if (rise) begin
			in_shift <= {sync_b[0], in_shift[BITS-1:1]};
			count <= (count == 5'h1F) ? count : count + 5'h01;
		end
	end

	// first byte shifts zeros, second byte the register before any write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_shift <= 8'h00;
			spi_miso <= 1'b0;
			spi_miso_oe <= 1'b0;
		end else begin
			spi_miso_oe <= !cs_n;
			if (cs_prev_n && !cs_n) begin
				out_shift <= 8'h00;
				spi_miso <= 1'b0;
			end else if (fall && count == 5'(DATA_LO)) begin
				spi_miso <= read_data[0];
				out_shift <= {1'b0, read_data[7:1]};
			end else if (fall) begin
				spi_miso <= out_shift[0];
				out_shift <= {1'b0, out_shift[7:1]};
			end
		end
	end

	// a frame counts only with exactly the full bit count at deselect
	always_ff @(posedge core_clk) begin
		if (rst) begin
			frame_valid <= 1'b0;
			frame_write <= 1'b0;
			frame_addr <= 7'h00;
			frame_data <= 8'h00;
		end else begin
			frame_valid <= cs_n && !cs_prev_n && count == 5'(BITS);
			frame_addr <= in_shift[ADDR_BITS-1:0];
			frame_write <= in_shift[WRITE_BIT];
			frame_data <= in_shift[BITS-1 -: 8];
		end
	end

	AST_FULL_FRAME: assert property (@(posedge core_clk) disable iff (rst)
		frame_valid |-> $past(count) == 5'(BITS))
		else $error("frame accepted with wrong bit count");
endmodule : spi_frame_port
`default_nettype wire

// ===== mode_supply_control_regs.sv
// mode and supply control register pair with hardware updates and derived controls
`timescale 1ns/1ns
`default_nettype none
module mode_supply_control_regs
	import sbc_ctrl_pkg::*;
#(
	parameter int SOFT_LOW_CYCLES = SOFT_RESET_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// serial pins
	input wire logic spi_clk_pin,
	input wire logic spi_cs_n_pin,
	input wire logic spi_mosi_pin,
	output logic spi_miso,
	output logic spi_miso_oe,
	// device state and events from the surrounding logic
	input wire logic [3:0] sbc_state,
	input wire logic high_power,
	input wire logic restart_entry,
	input wire logic over_temp,
	input wire logic main_ov_event,
	input wire logic main_ov_flag_clear,
	input wire logic battery_undervoltage,
	input wire logic failure_flag,
	input wire logic wd_fail,
	// mode control
	output logic [1:0] mode_request,
	output logic soft_reset_pulse,
	output logic reset_output_pin_n,
	// supply control
	output logic second_regulator_on,
	output logic third_regulator_on,
	output logic third_regulator_alt_level,
	output logic third_regulator_load_sharing,
	output logic [1:0] main_reset_threshold,
	output logic main_overvoltage_flag,
	output logic ov_escalate,
	// failure and watchdog handling
	output logic failure_outputs,
	output logic wd_escalate
);
	initial begin
		if (SOFT_LOW_CYCLES < 1 || SOFT_LOW_CYCLES > 65535) $error("soft reset length out of range");
	end

	logic [7:0] mode_supply_control;
	logic [7:0] hardware_config_control;
	logic frame_valid;
	logic frame_write;
	logic [6:0] frame_addr;
	logic [7:0] frame_data;
	logic [6:0] live_addr;
	logic [7:0] read_data;
	logic wr_ms;
	logic wr_hw;
	logic soft_go;
	soft_state_t soft_state;
	logic [15:0] soft_count;
	logic wd_seen;
	logic in_stop;
	logic [16:0] ro_low_len;

	// register read mux, unmapped addresses read zero
	function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] ms,
		input logic [7:0] hw);
		logic [7:0] r;
		r = 8'h00;
		if (a == ADDR_MODE_SUPPLY) r = ms;
		else if (a == ADDR_HW_CONFIG) r = hw & HW_WRITABLE;
		return r;
	endfunction : reg_read

	// merge of a written mode byte; stop to sleep keeps the old mode code
	function automatic logic [7:0] ms_merge(input logic [7:0] old, input logic [7:0] d,
		input logic stop);
		logic [7:0] r;
		r = d;
		if (stop && d[MS_MODE_LO +: 2] == MODE_SLEEP) r[MS_MODE_LO +: 2] = old[MS_MODE_LO +: 2];
		return r;
	endfunction : ms_merge

	// second regulator decode against the present state
	function automatic logic v2_decode(input logic [1:0] code, input logic [3:0] st);
		logic r;
		r = 1'b0;
		case (code)
			V2_NORMAL: r = st == ST_NORMAL;
			V2_NORM_STOP: r = st == ST_NORMAL || st == ST_STOP;
			V2_ALWAYS: r = st != ST_FAIL_SAFE;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : v2_decode

	spi_frame_port #(
		.BITS(FRAME_BITS)
	) port_i (
		.core_clk(core_clk),
		.rst(rst),
		.spi_clk_pin(spi_clk_pin),
		.spi_cs_n_pin(spi_cs_n_pin),
		.spi_mosi_pin(spi_mosi_pin),
		.spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe),
		.read_data(read_data),
		.live_addr(live_addr),
		.frame_valid(frame_valid),
		.frame_write(frame_write),
		.frame_addr(frame_addr),
		.frame_data(frame_data)
	);

	// readback uses the stored value, so a write returns the old content
	assign read_data = reg_read(live_addr, mode_supply_control, hardware_config_control);
	assign wr_ms = frame_valid && frame_write && frame_addr == ADDR_MODE_SUPPLY;
	assign wr_hw = frame_valid && frame_write && frame_addr == ADDR_HW_CONFIG;
	assign soft_go = wr_ms && !restart_entry
		&& frame_data[MS_MODE_LO +: 2] == MODE_SOFT_RESET;
	assign in_stop = sbc_state == ST_STOP;

	// mode and supply register; restart outranks soft reset, which outranks writes
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_supply_control <= MS_RESET;
		end else if (restart_entry) begin
			mode_supply_control <= mode_supply_control & MS_RESTART_KEEP;
		end else if (soft_go) begin
			mode_supply_control <= MS_RESET;
		end else begin
			if (wr_ms) begin
				mode_supply_control <= ms_merge(mode_supply_control, frame_data, in_stop);
			end
			if (over_temp) begin
				mode_supply_control[MS_V2_LO +: 2] <= V2_OFF;
			end
		end
	end

	// hardware configuration register; bit 2 is never stored
	always_ff @(posedge core_clk) begin
		if (rst) begin
			hardware_config_control <= HW_RESET;
		end else if (restart_entry) begin
			hardware_config_control <= hardware_config_control & HW_RESTART_KEEP;
		end else if (soft_go) begin
			hardware_config_control <= hardware_config_control & HW_SOFT_KEEP;
		end else if (wr_hw) begin
			hardware_config_control <= frame_data & HW_WRITABLE;
		end
	end

	// soft reset sequencer: holds the reset output low for a fixed time
	always_ff @(posedge core_clk) begin
		if (rst) begin
			soft_state <= SR_IDLE;
			soft_count <= 16'h0000;
		end else begin
			case (soft_state)
				SR_IDLE: begin
					if (soft_go) begin
						soft_state <= SR_ACTIVE;
						soft_count <= 16'(SOFT_LOW_CYCLES - 1);
					end
				end
				SR_ACTIVE: begin
					if (soft_count == 16'h0000) soft_state <= SR_IDLE;
					else soft_count <= soft_count - 16'h0001;
				end
				default: soft_state <= SR_IDLE;
			endcase
		end
	end

	// mode outputs; the reset output bit survives soft reset so it is read afterwards
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_request <= MODE_NORMAL;
			soft_reset_pulse <= 1'b0;
			reset_output_pin_n <= 1'b1;
		end else begin
			mode_request <= mode_supply_control[MS_MODE_LO +: 2];
			soft_reset_pulse <= soft_go;
			reset_output_pin_n <= !(soft_state == SR_ACTIVE
				&& !hardware_config_control[HW_RO_SOFT]);
		end
	end

	// supply outputs, registered one cycle behind the fields
	always_ff @(posedge core_clk) begin
		if (rst) begin
			second_regulator_on <= 1'b0;
			third_regulator_on <= 1'b0;
			third_regulator_alt_level <= 1'b0;
			third_regulator_load_sharing <= 1'b0;
			main_reset_threshold <= 2'h0;
		end else begin
			second_regulator_on <= v2_decode(mode_supply_control[MS_V2_LO +: 2], sbc_state);
			third_regulator_on <= mode_supply_control[MS_V3_ON]
				&& !(battery_undervoltage && !hardware_config_control[HW_UV_KEEP])
				&& !(hardware_config_control[HW_LS] && (in_stop || high_power)
				&& !hardware_config_control[HW_LS_STOP]);
			third_regulator_alt_level <= hardware_config_control[HW_VSEL]
				&& !hardware_config_control[HW_LS];
			third_regulator_load_sharing <= hardware_config_control[HW_LS];
			main_reset_threshold <= mode_supply_control[MS_RT_LO +: 2];
		end
	end

	// over-voltage flag: a new event wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			main_overvoltage_flag <= 1'b0;
			ov_escalate <= 1'b0;
		end else begin
			if (main_ov_event) main_overvoltage_flag <= 1'b1;
			else if (main_ov_flag_clear) main_overvoltage_flag <= 1'b0;
			ov_escalate <= main_ov_event && mode_supply_control[MS_OV_REACT];
		end
	end

	// failure outputs; the failure flag is cleared by the host elsewhere
	always_ff @(posedge core_clk) begin
		if (rst) failure_outputs <= 1'b0;
		else failure_outputs <= (hardware_config_control[HW_FO_SW] && !restart_entry)
			|| failure_flag;
	end

	// watchdog escalation: one remembered failure unless first failure escalates
	always_ff @(posedge core_clk) begin
		if (rst || restart_entry) begin
			wd_seen <= 1'b0;
			wd_escalate <= 1'b0;
		end else begin
			wd_escalate <= wd_fail && (hardware_config_control[HW_CFG] || wd_seen);
			if (wd_fail) wd_seen <= !(hardware_config_control[HW_CFG] || wd_seen);
		end
	end

	// length of the present low phase of the reset output, checked when it ends
	always_ff @(posedge core_clk) begin
		if (rst) ro_low_len <= 17'h00000;
		else if (!reset_output_pin_n) ro_low_len <= ro_low_len + 17'h00001;
		else ro_low_len <= 17'h00000;
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	AST_SOFT_CLEAR: assert property (soft_go |=> mode_supply_control == MS_RESET
		&& hardware_config_control == ($past(hardware_config_control) & HW_SOFT_KEEP))
		else $error("soft reset values wrong");
	AST_RO_LOW: assert property (soft_go && !hardware_config_control[HW_RO_SOFT]
		|-> ##2 !reset_output_pin_n)
		else $error("reset output not low during soft reset");
	AST_RO_LEN: assert property (reset_output_pin_n && ro_low_len != 17'h00000
		|-> ro_low_len == 17'(SOFT_LOW_CYCLES))
		else $error("reset output low time wrong");
	AST_RO_KEPT: assert property (soft_go && hardware_config_control[HW_RO_SOFT]
		|-> ##2 reset_output_pin_n [*8])
		else $error("reset output pulled despite configuration");
	AST_NO_STOP_SLEEP: assert property (wr_ms && in_stop && !restart_entry
		&& frame_data[MS_MODE_LO +: 2] == MODE_SLEEP
		|=> mode_supply_control[MS_MODE_LO +: 2] == $past(mode_supply_control[MS_MODE_LO +: 2]))
		else $error("stop to sleep accepted");
	AST_RESTART: assert property (restart_entry |=>
		mode_supply_control[7:6] == 2'h0 && mode_supply_control[4:2] == 3'h0
		&& hardware_config_control[HW_FO_SW] == 1'b0 && failure_outputs == $past(failure_flag))
		else $error("restart values wrong");
	AST_OT_V2: assert property (over_temp |=> mode_supply_control[MS_V2_LO +: 2] == V2_OFF)
		else $error("second regulator not forced off");
	AST_V3_EN: assert property (third_regulator_on |-> $past(mode_supply_control[MS_V3_ON]))
		else $error("third regulator on while disabled");
	AST_UV_OFF: assert property (battery_undervoltage
		&& !hardware_config_control[HW_UV_KEEP] |=> !third_regulator_on)
		else $error("third regulator kept on at under-voltage");
	AST_OV_FLAG: assert property (main_ov_event |=> main_overvoltage_flag
		&& ov_escalate == $past(mode_supply_control[MS_OV_REACT]))
		else $error("over-voltage handling wrong");
	AST_RSVD: assert property (read_data[2] == 1'b0 || live_addr != ADDR_HW_CONFIG)
		else $error("reserved bit reads one");
	AST_WD_ESC: assert property (wd_fail && !restart_entry
		&& hardware_config_control[HW_CFG] |=> wd_escalate)
		else $error("first watchdog failure not escalated");
	AST_FO: assert property (failure_flag && !restart_entry |=> failure_outputs)
		else $error("failure outputs released");

	COV_SOFT: cover property (soft_go ##2 !reset_output_pin_n);
	COV_STOP_SLEEP: cover property (wr_ms && in_stop && frame_data[7:6] == MODE_SLEEP);
	COV_WD_SECOND: cover property (wd_fail && !hardware_config_control[HW_CFG] && wd_seen);
	COV_RESTART: cover property (restart_entry && hardware_config_control[HW_FO_SW]);
endmodule : mode_supply_control_regs
`default_nettype wire

// ===== spi_host_model.sv
// host-side serial master model: 16-bit mode 0 frames, lsb first
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	// clock
	input wire logic core_clk,
	// serial pins
	output logic spi_clk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	logic junk = 1'b0;
	wire logic miso_line;

	// a released data line shows a changing pattern, never its last value
	always @(posedge core_clk) begin
		junk <= ~junk;
	end
	assign miso_line = miso_oe ? miso : junk;

	// idle pins: clock low, deselected
	initial begin
		spi_clk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// one frame of n clocks; the serial clock stands still low between frames
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge core_clk);
		cs_n <= 1'b0;
		mosi <= tx[0];
		repeat (4) @(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			spi_clk <= 1'b1; // device samples mosi on this rising clock
			repeat (3) @(posedge core_clk);
			if (i < 16) rx[i] = miso_line;
			@(posedge core_clk);
			spi_clk <= 1'b0;
			mosi <= tx[(i + 1) % 16];
			repeat (4) @(posedge core_clk);
		end
		cs_n <= 1'b1;
		mosi <= ~mosi;
		// gap covers frame completion and derived outputs, and the minimum deselect time
		repeat (8) @(posedge core_clk);
	endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ===== mode_supply_control_regs_tb_top.sv
// self-checking testbench for the mode and supply control register pair
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module mode_supply_control_regs_tb_top;
	import sbc_ctrl_pkg::*;
	localparam int SOFT_LOW = 5;
	localparam int EV_RESTART = 0;
	localparam int EV_OT = 1;
	localparam int EV_OV = 2;
	localparam int EV_OV_CLR = 3;
	localparam int EV_WD = 4;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	wire logic spi_clk;
	wire logic cs_n;
	wire logic mosi;
	logic miso, miso_oe;
	logic [3:0] sbc_state = ST_NORMAL;
	logic high_power = 1'b0;
	logic bat_uv = 1'b0;
	logic failure_flag = 1'b0;
	logic [4:0] ev = 5'h00;
	logic [1:0] mode_request, main_reset_threshold;
	logic soft_reset_pulse, reset_output_pin_n, second_regulator_on, third_regulator_on;
	logic third_regulator_alt_level, third_regulator_load_sharing, main_overvoltage_flag;
	logic ov_escalate, failure_outputs, wd_escalate;
	int n_checks = 0;
	int err_total = 0;
	int n_low = 0;
	int n_soft = 0;
	int n_ove = 0;
	int n_wde = 0;

	mode_supply_control_regs #(.SOFT_LOW_CYCLES(SOFT_LOW)) u_dut (
		.core_clk, .rst, .spi_clk_pin(spi_clk), .spi_cs_n_pin(cs_n), .spi_mosi_pin(mosi),
		.spi_miso(miso), .spi_miso_oe(miso_oe), .sbc_state, .high_power,
		.restart_entry(ev[EV_RESTART]), .over_temp(ev[EV_OT]), .main_ov_event(ev[EV_OV]),
		.main_ov_flag_clear(ev[EV_OV_CLR]), .battery_undervoltage(bat_uv), .failure_flag,
		.wd_fail(ev[EV_WD]), .mode_request, .soft_reset_pulse, .reset_output_pin_n,
		.second_regulator_on, .third_regulator_on, .third_regulator_alt_level,
		.third_regulator_load_sharing, .main_reset_threshold, .main_overvoltage_flag,
		.ov_escalate, .failure_outputs, .wd_escalate);

	spi_host_model u_host (.core_clk, .spi_clk, .cs_n, .mosi, .miso, .miso_oe(miso_oe));

	// 10 MHz core clock
	initial begin
		forever #50 core_clk = ~core_clk;
	end

	// pulse and low-time counters; scenarios compare deltas so nothing races a clear
	always @(posedge core_clk) begin
		if (reset_output_pin_n === 1'b0) n_low++;
		if (soft_reset_pulse === 1'b1) n_soft++;
		if (ov_escalate === 1'b1) n_ove++;
		if (wd_escalate === 1'b1) n_wde++;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	task automatic pulse(input int k);
		ev[k] <= 1'b1;
		tick(1);
		ev <= 5'h00;
		tick(3);
	endtask : pulse

	task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d, input int n,
			output logic [7:0] q);
		logic [15:0] rx;
		u_host.xfer({d, w, a}, n, rx);
		q = rx[15:8];
	endtask : acc

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, 16, q);
	endtask : wr

	task automatic chk_reg(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] q;
		acc(1'b0, a, 8'h00, 16, q);
		`CHK("reg", e, q)
	endtask : chk_reg

	task automatic t_reset();
		chk_reg(ADDR_MODE_SUPPLY, 8'h00);
		chk_reg(ADDR_HW_CONFIG, 8'h00);
	endtask : t_reset

	// supply controls, write answers and the read-only bit
	task automatic t_write();
		logic [7:0] q;
		wr(ADDR_MODE_SUPPLY, 8'h27);
		`CHK("thr", 2'h3, main_reset_threshold)
		`CHK("v3on", 1'b1, third_regulator_on)
		acc(1'b1, ADDR_HW_CONFIG, 8'hFF, 16, q);
		`CHK("old", 8'h00, q)
		`CHK("fo", 1'b1, failure_outputs)
		`CHK("ls", 1'b1, third_regulator_load_sharing)
		`CHK("alt", 1'b0, third_regulator_alt_level)
		acc(1'b1, ADDR_HW_CONFIG, 8'h80, 16, q);
		`CHK("old", 8'hFB, q)
		`CHK("alt", 1'b1, third_regulator_alt_level)
		`CHK("ls", 1'b0, third_regulator_load_sharing)
		`CHK("fo", 1'b0, failure_outputs)
		bat_uv <= 1'b1;
		tick(3);
		`CHK("v3uv", 1'b0, third_regulator_on)
		wr(ADDR_HW_CONFIG, 8'h90);
		`CHK("v3uv", 1'b1, third_regulator_on)
		bat_uv <= 1'b0;
		wr(ADDR_HW_CONFIG, 8'h08);
		sbc_state <= ST_STOP;
		tick(3);
		`CHK("v3stp", 1'b0, third_regulator_on)
		sbc_state <= ST_NORMAL;
		high_power <= 1'b1;
		tick(3);
		`CHK("v3hp", 1'b0, third_regulator_on)
		high_power <= 1'b0;
		sbc_state <= ST_STOP;
		wr(ADDR_HW_CONFIG, 8'h0A);
		`CHK("v3stp", 1'b1, third_regulator_on)
		sbc_state <= ST_NORMAL;
		wr(ADDR_MODE_SUPPLY, 8'h07);
		`CHK("v3off", 1'b0, third_regulator_on)
	endtask : t_write

	// soft reset with and without the reset output
	task automatic t_soft();
		int b0, b1;
		wr(ADDR_HW_CONFIG, 8'hBB);
		b0 = n_low;
		b1 = n_soft;
		wr(ADDR_MODE_SUPPLY, 8'hC0);
		tick(4);
		`CHK("rolow", SOFT_LOW, n_low - b0)
		`CHK("srp", 1, n_soft - b1)
		chk_reg(ADDR_MODE_SUPPLY, 8'h00);
		chk_reg(ADDR_HW_CONFIG, 8'h89);
		wr(ADDR_HW_CONFIG, 8'h40);
		b0 = n_low;
		wr(ADDR_MODE_SUPPLY, 8'hC0);
		tick(4);
		`CHK("rolow", 0, n_low - b0)
		chk_reg(ADDR_HW_CONFIG, 8'h40);
	endtask : t_soft

	// mode decode and the refused stop-to-sleep request
	task automatic t_modes();
		for (int m = 0; m < 3; m++) begin
			wr(ADDR_MODE_SUPPLY, {m[1:0], 6'h00});
			`CHK("mode", m[1:0], mode_request)
		end
		sbc_state <= ST_STOP;
		wr(ADDR_MODE_SUPPLY, 8'h43);
		chk_reg(ADDR_MODE_SUPPLY, 8'h83);
		`CHK("mode", 2'h2, mode_request)
		sbc_state <= ST_NORMAL;
	endtask : t_modes

	task automatic t_restart();
		wr(ADDR_MODE_SUPPLY, 8'hBF);
		wr(ADDR_HW_CONFIG, 8'hFF);
		pulse(EV_RESTART);
		chk_reg(ADDR_MODE_SUPPLY, 8'h23);
		chk_reg(ADDR_HW_CONFIG, 8'hD9);
		`CHK("fo", 1'b0, failure_outputs)
	endtask : t_restart

	// second regulator over every code and state, then over-temperature
	task automatic t_v2();
		logic e;
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_MODE_SUPPLY, {3'h0, c[1:0], 3'h0});
			for (int s = 0; s < 4; s++) begin
				sbc_state <= 4'h1 << s;
				tick(3);
				e = (s == 0) ? (c != 0) : (s == 1) ? (c == 3) : (s == 2) ? (c >= 2) : 1'b0;
				`CHK("v2", e, second_regulator_on)
			end
		end
		sbc_state <= ST_NORMAL;
		tick(3);
		pulse(EV_OT);
		`CHK("v2ot", 1'b0, second_regulator_on)
		chk_reg(ADDR_MODE_SUPPLY, 8'h00);
	endtask : t_v2

	task automatic t_ov();
		int b;
		b = n_ove;
		pulse(EV_OV);
		`CHK("ovf", 1'b1, main_overvoltage_flag)
		`CHK("ove", 0, n_ove - b)
		pulse(EV_OV_CLR);
		`CHK("ovf", 1'b0, main_overvoltage_flag)
		wr(ADDR_MODE_SUPPLY, 8'h04);
		pulse(EV_OV);
		`CHK("ove", 1, n_ove - b)
	endtask : t_ov

	task automatic t_wd();
		int b;
		wr(ADDR_HW_CONFIG, 8'h00);
		b = n_wde;
		pulse(EV_WD);
		`CHK("wde", 0, n_wde - b)
		pulse(EV_WD);
		`CHK("wde", 1, n_wde - b)
		wr(ADDR_HW_CONFIG, 8'h01);
		pulse(EV_WD);
		`CHK("wde", 2, n_wde - b)
	endtask : t_wd

	// failure outputs held by a failure after the software bit is cleared
	task automatic t_fo();
		wr(ADDR_HW_CONFIG, 8'h20);
		`CHK("fo", 1'b1, failure_outputs)
		failure_flag <= 1'b1;
		wr(ADDR_HW_CONFIG, 8'h00);
		`CHK("fo", 1'b1, failure_outputs)
		failure_flag <= 1'b0;
		tick(3);
		`CHK("fo", 1'b0, failure_outputs)
	endtask : t_fo

	// short, long and read frames leave the register alone
	task automatic t_frames();
		logic [7:0] q;
		wr(ADDR_MODE_SUPPLY, 8'h01);
		acc(1'b1, ADDR_MODE_SUPPLY, 8'h02, 15, q);
		acc(1'b1, ADDR_MODE_SUPPLY, 8'h02, 17, q);
		chk_reg(ADDR_MODE_SUPPLY, 8'h01);
		acc(1'b0, ADDR_MODE_SUPPLY, 8'h03, 16, q);
		chk_reg(ADDR_MODE_SUPPLY, 8'h01);
		wr(7'h7F, 8'hFF);
		chk_reg(7'h7F, 8'h00);
	endtask : t_frames

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	// main sequence
	initial begin
		tick(3);
		rst <= 1'b0;
		tick(2);
		t_reset();
		t_write();
		t_soft();
		t_modes();
		t_restart();
		t_v2();
		t_ov();
		t_wd();
		t_fo();
		t_frames();
		end_of_test();
	end

	// hang guard, well beyond the roughly 6200 cycles the sequence needs
	initial begin
		tick(60000);
		err_total++;
		end_of_test();
	end
endmodule : mode_supply_control_regs_tb_top
`default_nettype wire
